// file: rtl/tie_top.sv
// Purpose: ttl incremental encoder channel with ahb-lite registers
// Assumes: track pins are asynchronous, single word transfers only
// Notes: gearing result refreshes every 134 cycles
`timescale 1ns/1ps
`default_nettype none
`include "tie_cfg.svh"
module tie_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        enc_track_a,
  input  wire logic        enc_track_b,
  input  wire logic        enc_index,
  input  wire logic        comm_u,
  input  wire logic        comm_v,
  input  wire logic        comm_w,
  output logic             index_toggle_probe,
  output logic             index_home_pulse
);
  tie_pkg::tie_top_s q;
  tie_pkg::tie_top_s d;
  tie_div_if         div_bus ();

  tie_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (div_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [2:0] seg_of(input logic [2:0] uvw);
    case (uvw)
      3'b100:  seg_of = 3'h1;
      3'b110:  seg_of = 3'h2;
      3'b010:  seg_of = 3'h3;
      3'b011:  seg_of = 3'h4;
      3'b001:  seg_of = 3'h5;
      3'b101:  seg_of = 3'h6;
      default: seg_of = 3'h0;
    endcase
  endfunction : seg_of

  function automatic logic [31:0] rd_mux(input tie_pkg::tie_top_s s,
                                         input logic [7:0]       a);
    case (a)
      `TIE_OFF_CTRL:   rd_mux = {22'h0, s.sig_type, 3'h0, s.test_en, 1'b0, s.enc_sel};
      `TIE_OFF_NUM:    rd_mux = s.num;
      `TIE_OFF_DEN:    rd_mux = s.den;
      `TIE_OFF_PPR:    rd_mux = {15'h0, s.ppr};
      `TIE_OFF_SINGLE: rd_mux = s.single;
      `TIE_OFF_MULTI:  rd_mux = s.multi;
      `TIE_OFF_IDXCNT: rd_mux = s.idx_cnt;
      `TIE_OFF_STATUS: rd_mux = {26'h0, s.comm_fault, s.probe, 1'b0, s.seg};
      `TIE_OFF_RAW:    rd_mux = s.raw;
      default:         rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////////////
  // track decode

  logic        a_now;
  logic        b_now;
  logic        r_now;
  logic        a_old;
  logic        b_old;
  logic        r_old;
  logic        chan_on;
  logic        a_rise;
  logic        a_fall;
  logic        idx_rise;
  logic        quad_en;
  logic        quad_up;
  logic        step_en;
  logic        step_up;
  logic        sel_ph;
  logic [63:0] prod;
  logic [63:0] scaled_mag;

  assign a_now    = q.s2[0];
  assign b_now    = q.s2[1];
  assign r_now    = q.s2[2];
  assign a_old    = q.prev[0];
  assign b_old    = q.prev[1];
  assign r_old    = q.prev[2];
  assign a_rise   = a_now & ~a_old;
  assign a_fall   = ~a_now & a_old;
  assign idx_rise = r_now & ~r_old;
  // only type 3 runs the channel
  assign chan_on  = (q.enc_sel == `TIE_SEL_TTL);
  // one track changed: a leading b counts up
  assign quad_en  = (a_now ^ a_old) ^ (b_now ^ b_old);
  assign quad_up  = a_now ^ b_old;
  assign sel_ph   = hsel & htrans[1] & hready;
  assign prod     = $signed({{32{q.raw[31]}}, q.raw}) * $signed({{32{q.num[31]}}, q.num});
  assign scaled_mag = q.scaled[63] ? 64'(-q.scaled) : q.scaled;

  always_comb begin
    step_en = 1'b0;
    step_up = 1'b0;
    case (q.sig_type)
      `TIE_TYP_QFWD: begin
        step_en = quad_en;
        step_up = quad_up;
      end
      `TIE_TYP_QREV: begin
        step_en = quad_en;
        step_up = ~quad_up;
      end
      `TIE_TYP_SDFALL: begin
        step_en = a_fall;
        step_up = b_now;
      end
      `TIE_TYP_SDRISE: begin
        step_en = a_rise;
        step_up = b_now;
      end
      default: begin
        step_en = 1'b0;
        step_up = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.s1 = {comm_w, comm_v, comm_u, enc_index, enc_track_b, enc_track_a};
    d.s2 = q.s1;
    d.prev = q.s2;
    d.home = 1'b0;
    d.dv_start = 1'b0;
    d.ready = 1'b1;
    d.ph_wr = sel_ph & hwrite;
    d.ph_addr = haddr[7:0];
    if (sel_ph && !hwrite) begin
      d.rdata = rd_mux(q, haddr[7:0]);
    end
    if (q.ph_wr) begin
      case (q.ph_addr)
        `TIE_OFF_CTRL: begin
          d.enc_sel = hwdata[`TIE_CTRL_SEL_LSB +: 3];
          d.test_en = hwdata[`TIE_CTRL_TEST];
          d.sig_type = hwdata[`TIE_CTRL_TYP_LSB +: 2];
        end
        `TIE_OFF_NUM: d.num = hwdata;
        `TIE_OFF_DEN: begin
          if (!hwdata[31] && hwdata != 32'h0) begin
            d.den = hwdata;
          end
        end
        `TIE_OFF_PPR: begin
          if (hwdata != 32'h0 && hwdata <= `TIE_PPR_MAX) begin
            d.ppr = hwdata[16:0];
          end
        end
        default: d.ppr = q.ppr;
      endcase
    end
    if (chan_on && step_en) begin
      d.raw = step_up ? q.raw + 32'sh1 : q.raw - 32'sh1;
    end
    if (idx_rise) begin
      d.idx_cnt = q.idx_cnt + 32'h1;
      if (q.test_en) begin
        d.probe = ~q.probe;
      end else if (chan_on) begin
        d.home = 1'b1;
      end
    end
    if (seg_of(q.s2[5:3]) != 3'h0) begin
      d.seg = seg_of(q.s2[5:3]);
      d.comm_fault = 1'b0;
    end else begin
      d.comm_fault = 1'b1;
    end
    case (q.gs)
      // magnitude of raw times numerator over denominator
      tie_pkg::gs_idle: begin
        d.sneg = prod[63];
        d.dv_dividend = prod[63] ? 64'(-prod) : prod;
        d.dv_divisor = q.den;
        d.dv_start = 1'b1;
        d.gs = tie_pkg::gs_wait1;
      end
      tie_pkg::gs_wait1: begin
        if (div_bus.done) begin
          d.scaled = q.sneg ? 64'(-div_bus.quot) : div_bus.quot;
          d.gs = tie_pkg::gs_div2;
        end
      end
      tie_pkg::gs_div2: begin
        d.dv_dividend = scaled_mag;
        d.dv_divisor = {15'h0, q.ppr};
        d.dv_start = 1'b1;
        d.gs = tie_pkg::gs_wait2;
      end
      // split into turns, floor for negatives
      tie_pkg::gs_wait2: begin
        if (div_bus.done) begin
          if (!q.scaled[63]) begin
            d.multi = div_bus.quot[31:0];
            d.single = div_bus.rem;
          end else if (div_bus.rem == 32'h0) begin
            d.multi = 32'(-div_bus.quot[31:0]);
            d.single = 32'h0;
          end else begin
            d.multi = 32'(~div_bus.quot[31:0]);
            d.single = q.dv_divisor - div_bus.rem;
          end
          d.gs = tie_pkg::gs_idle;
        end
      end
      default: d.gs = tie_pkg::gs_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.num <= `TIE_RST_NUM;
      q.den <= `TIE_RST_DEN;
      q.ppr <= `TIE_RST_PPR;
      q.ready <= 1'b1;
      q.seg <= 3'h1;
      q.gs <= tie_pkg::gs_idle;
    end else begin
      q <= d;
    end
  end

  assign div_bus.start    = q.dv_start;
  assign div_bus.dividend = q.dv_dividend;
  assign div_bus.divisor  = q.dv_divisor;
  assign hreadyout          = q.ready;
  assign hrdata             = q.rdata;
  assign hresp              = 1'b0;
  assign index_toggle_probe = q.probe;
  assign index_home_pulse   = q.home;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_chan_off_hold: assert property (!chan_on |=> $stable(q.raw))
    else $error("raw count moved while channel off");
  a_den_positive: assert property (!q.den[31] && q.den != 32'h0)
    else $error("denominator left its range");
  a_ppr_range: assert property (q.ppr != 17'h0 && {15'h0, q.ppr} <= `TIE_PPR_MAX)
    else $error("pulses per revolution left its range");
  a_quad_step: assert property ((chan_on && q.sig_type == `TIE_TYP_QFWD && quad_en)
    |=> q.raw == $past(q.raw) + ($past(quad_up) ? 32'sh1 : -32'sh1))
    else $error("forward quadrature step wrong");
  a_quad_reverse: assert property ((chan_on && q.sig_type == `TIE_TYP_QREV && quad_en)
    |=> q.raw == $past(q.raw) + ($past(quad_up) ? -32'sh1 : 32'sh1))
    else $error("reverse quadrature step wrong");
  a_fall_only: assert property ((q.sig_type == `TIE_TYP_SDFALL && !a_fall)
    |=> $stable(q.raw))
    else $error("falling step mode counted without falling edge");
  a_rise_count: assert property ((chan_on && q.sig_type == `TIE_TYP_SDRISE && a_rise)
    |=> q.raw == $past(q.raw) + ($past(b_now) ? 32'sh1 : -32'sh1))
    else $error("rising step mode count wrong");
  a_single_below: assert property ((q.gs == tie_pkg::gs_wait2 && div_bus.done)
    |=> q.single < q.dv_divisor)
    else $error("single-turn value not below pulses per revolution");
  a_probe_toggle: assert property ((idx_rise && q.test_en) |=> q.probe != $past(q.probe))
    else $error("probe did not toggle on index");
  a_probe_hold: assert property (!idx_rise |=> $stable(q.probe))
    else $error("probe moved without index");
  a_home_masked: assert property (q.test_en |=> !q.home)
    else $error("homing pulse during index test");
  a_index_count: assert property (idx_rise |=> q.idx_cnt == $past(q.idx_cnt) + 32'h1)
    else $error("index pulse not counted");
  a_seg_valid: assert property (q.seg != 3'h0 && q.seg <= 3'h6)
    else $error("commutation segment out of range");
endmodule : tie_top
`default_nettype wire

// file: rtl/tie_cfg.svh
// Purpose: constants of the ttl incremental encoder channel
// Assumes: ahb-lite byte addresses, hclk at 100 MHz
// Notes: all offsets are byte addresses of aligned 32-bit words
// Behaviour
// - encoder type 0 switches the channel off, 3 runs incremental with index, others do nothing
// - the gearing numerator takes any signed 32-bit value
// - the gearing denominator takes only 1 to 2^31-1, other writes are dropped
// - pulses per revolution takes 1 to 65536, other writes are dropped
// - index test enable 0 leaves the test off, 1 turns the test mode on
// - signal type 0 decodes a/b quadrature counting in the master's direction
// - signal type 1 decodes a/b quadrature with the count direction reversed
// - signal type 2 is step on a, direction on b, b high is positive, falling a counts
// - signal type 3 is step on a, direction on b, b low is negative, rising a counts
// - the raw position reads as a single-turn word and a multi-turn word after gearing
// - in test mode the probe toggles at every index pulse and holds until the next
// - in test mode index pulses give no homing pulse
// - every index pulse is counted whatever the test mode
// - three commutation tracks decode to one of six segments, updated on valid codes, held on 000 and 111
`ifndef TIE_CFG_SVH
`define TIE_CFG_SVH
`define TIE_OFF_CTRL     8'h00
`define TIE_OFF_NUM      8'h04
`define TIE_OFF_DEN      8'h08
`define TIE_OFF_PPR      8'h0c
`define TIE_OFF_SINGLE   8'h10
`define TIE_OFF_MULTI    8'h14
`define TIE_OFF_IDXCNT   8'h18
`define TIE_OFF_STATUS   8'h1c
`define TIE_OFF_RAW      8'h20
`define TIE_CTRL_SEL_LSB 0
`define TIE_CTRL_TEST    4
`define TIE_CTRL_TYP_LSB 8
`define TIE_SEL_OFF      3'h0
`define TIE_SEL_TTL      3'h3
`define TIE_TYP_QFWD     2'h0
`define TIE_TYP_QREV     2'h1
`define TIE_TYP_SDFALL   2'h2
`define TIE_TYP_SDRISE   2'h3
`define TIE_RST_NUM      32'h00000001
`define TIE_RST_DEN      32'h00000001
`define TIE_RST_PPR      17'h00400
`define TIE_PPR_MAX      32'h00010000
`define TIE_DIV_STEPS    7'h40
`endif

// file: rtl/tie_pkg.sv
// Purpose: types of the ttl incremental encoder channel
// Assumes: constants come from tie_cfg.svh
// Notes: one state struct per module
`include "tie_cfg.svh"
package tie_pkg;
  typedef enum logic [1:0] {
    gs_idle  = 2'b00,
    gs_wait1 = 2'b01,
    gs_div2  = 2'b10,
    gs_wait2 = 2'b11
  } tie_gear_e;

  typedef struct packed {
    logic [5:0]         s1;
    logic [5:0]         s2;
    logic [5:0]         prev;
    logic [2:0]         enc_sel;
    logic               test_en;
    logic [1:0]         sig_type;
    logic [31:0]        num;
    logic [31:0]        den;
    logic [16:0]        ppr;
    logic signed [31:0] raw;
    logic [31:0]        idx_cnt;
    logic               probe;
    logic               home;
    logic [2:0]         seg;
    logic               comm_fault;
    tie_gear_e          gs;
    logic               sneg;
    logic signed [63:0] scaled;
    logic [31:0]        single;
    logic [31:0]        multi;
    logic               dv_start;
    logic [63:0]        dv_dividend;
    logic [31:0]        dv_divisor;
    logic               ph_wr;
    logic [7:0]         ph_addr;
    logic [31:0]        rdata;
    logic               ready;
  } tie_top_s;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [6:0]  cnt;
    logic [63:0] quot;
    logic [31:0] rem;
    logic [31:0] dvs;
  } tie_div_s;
endpackage : tie_pkg

// file: rtl/tie_div_if.sv
// Purpose: carrier between the channel and its divider
// Assumes: one clock, start only while the divider is idle
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface tie_div_if;
  logic        start;
  logic [63:0] dividend;
  logic [31:0] divisor;
  logic        done;
  logic [63:0] quot;
  logic [31:0] rem;
  modport user (output start, output dividend, output divisor,
                input done, input quot, input rem);
  modport engine (input start, input dividend, input divisor,
                  output done, output quot, output rem);
endinterface : tie_div_if
`default_nettype wire

// file: rtl/tie_div.sv
// Purpose: unsigned 64 by 32 restoring divider, one bit per cycle
// Assumes: divisor never zero
// Notes: done rises 64 cycles after start is taken
`timescale 1ns/1ps
`default_nettype none
`include "tie_cfg.svh"
module tie_div (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  tie_div_if.engine   bus
);
  tie_pkg::tie_div_s q;
  tie_pkg::tie_div_s d;

  always_comb begin
    logic [32:0] t;
    logic        bitv;
    t = 33'h0;
    bitv = 1'b0;
    d = q;
    d.done = 1'b0;
    if (!q.busy && bus.start) begin
      d.busy = 1'b1;
      d.cnt = 7'h00;
      d.quot = bus.dividend;
      d.rem = 32'h0;
      d.dvs = bus.divisor;
    end else if (q.busy) begin
      t = {q.rem, q.quot[63]};
      if (t >= {1'b0, q.dvs}) begin
        t = t - {1'b0, q.dvs};
        bitv = 1'b1;
      end
      d.rem = t[31:0];
      d.quot = {q.quot[62:0], bitv};
      d.cnt = q.cnt + 7'h01;
      if (q.cnt == `TIE_DIV_STEPS - 7'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.done = q.done;
  assign bus.quot = q.quot;
  assign bus.rem  = q.rem;

  a_div_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus.start && !q.busy) |=> ##64 q.done)
    else $error("divider done not 64 cycles after start");
endmodule : tie_div
`default_nettype wire

// file: tb/tie_enc_model.sv
// Purpose: far-side encoder for the ttl incremental channel bench
// Assumes: levels change just after a rising hclk edge
// Notes: every level is held 4 clocks, above the 3 the channel needs
`timescale 1ns/1ps
`default_nettype none
module tie_enc_model (
  input  wire logic hclk,
  output logic      trk_a,
  output logic      trk_b,
  output logic      trk_idx,
  output logic      cu,
  output logic      cv,
  output logic      cw
);
  ////////////////////////////////////////
  initial begin
    trk_a = 1'b0;
    trk_b = 1'b0;
    trk_idx = 1'b0;
    {cw, cv, cu} = 3'b100;
  end

  task automatic hold;
    repeat (4) @(posedge hclk);
  endtask : hold

  task automatic quad_step(input logic up);
    logic [1:0] s;
    s = {trk_a, trk_b};
    case (s)
      2'b00: s = up ? 2'b10 : 2'b01;
      2'b10: s = up ? 2'b11 : 2'b00;
      2'b11: s = up ? 2'b01 : 2'b10;
      default: s = up ? 2'b00 : 2'b11;
    endcase
    {trk_a, trk_b} <= s;
    hold();
  endtask : quad_step

  task automatic sd_pulse(input logic dir);
    trk_b <= dir;
    hold();
    trk_a <= ~trk_a;
    hold();
    trk_a <= ~trk_a;
    hold();
  endtask : sd_pulse

  task automatic index_pulse;
    trk_idx <= 1'b1;
    hold();
    trk_idx <= 1'b0;
    hold();
  endtask : index_pulse

  task automatic comm(input logic [2:0] c);
    {cw, cv, cu} <= c;
    hold();
  endtask : comm
endmodule : tie_enc_model
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench of the ttl incremental encoder channel
// Assumes: zero wait state ahb-lite slave, one clock
// Notes: expectations are worked out here from the register map
`timescale 1ns/1ps
`default_nettype none
`include "tie_cfg.svh"
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        wr_sel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        trk_a, trk_b, trk_idx, cu, cv, cw;
  logic        probe;
  logic        home;
  logic [31:0] rd;
  int          bad_count, compares, home_cnt, cycles;

  ////////////////////////////////////////
  tie_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .enc_track_a(trk_a), .enc_track_b(trk_b), .enc_index(trk_idx),
    .comm_u(cu), .comm_v(cv), .comm_w(cw),
    .index_toggle_probe(probe), .index_home_pulse(home));

  tie_enc_model enc_u (.hclk(hclk), .trk_a(trk_a), .trk_b(trk_b),
    .trk_idx(trk_idx), .cu(cu), .cv(cv), .cw(cw));

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (home === 1'b1) home_cnt++;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wait;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus_wait

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= wr_sel;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
  endtask : ahb_wr

  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    bus_wait();
    htrans <= 2'h0;
    bus_wait();
    d = hrdata;
  endtask : ahb_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb_rd(a, rd);
    check(rd, exp);
  endtask : rd_chk

  ////////////////////////////////////////
  task automatic t_reset;
    check({30'h0, hresp, hreadyout}, 32'h1);
    rd_chk(`TIE_OFF_CTRL, 32'h0);
    rd_chk(`TIE_OFF_NUM, `TIE_RST_NUM);
    rd_chk(`TIE_OFF_DEN, `TIE_RST_DEN);
    rd_chk(`TIE_OFF_PPR, 32'h00000400);
    rd_chk(`TIE_OFF_RAW, 32'h0);
    rd_chk(8'h24, 32'h0);
    $display("reset values done");
  endtask : t_reset

  task automatic t_limits;
    ahb_wr(`TIE_OFF_NUM, 32'h80000000);
    rd_chk(`TIE_OFF_NUM, 32'h80000000);
    wr_sel = 1'b0;
    ahb_wr(`TIE_OFF_NUM, 32'h00000007);
    wr_sel = 1'b1;
    rd_chk(`TIE_OFF_NUM, 32'h80000000);
    ahb_wr(`TIE_OFF_DEN, 32'h0);
    ahb_wr(`TIE_OFF_DEN, 32'h80000000);
    rd_chk(`TIE_OFF_DEN, 32'h1);
    ahb_wr(`TIE_OFF_DEN, 32'h7fffffff);
    rd_chk(`TIE_OFF_DEN, 32'h7fffffff);
    ahb_wr(`TIE_OFF_PPR, 32'h0);
    ahb_wr(`TIE_OFF_PPR, 32'h00010001);
    rd_chk(`TIE_OFF_PPR, 32'h400);
    ahb_wr(`TIE_OFF_PPR, `TIE_PPR_MAX);
    rd_chk(`TIE_OFF_PPR, `TIE_PPR_MAX);
    ahb_wr(`TIE_OFF_RAW, 32'h55);
    rd_chk(`TIE_OFF_RAW, 32'h0);
    $display("register limits done");
  endtask : t_limits

  task automatic t_quad;
    logic [31:0] base;
    ahb_rd(`TIE_OFF_RAW, base);
    ahb_wr(`TIE_OFF_CTRL, 32'h2);
    repeat (2) enc_u.quad_step(1'b1);
    rd_chk(`TIE_OFF_RAW, base);
    ahb_wr(`TIE_OFF_CTRL, 32'h3);
    repeat (4) enc_u.quad_step(1'b1);
    rd_chk(`TIE_OFF_RAW, base + 32'd4);
    ahb_wr(`TIE_OFF_CTRL, 32'h103);
    repeat (6) enc_u.quad_step(1'b1);
    rd_chk(`TIE_OFF_RAW, base - 32'd2);
    ahb_wr(`TIE_OFF_CTRL, 32'h0);
    repeat (3) enc_u.quad_step(1'b0);
    rd_chk(`TIE_OFF_RAW, base - 32'd2);
    $display("quadrature done");
  endtask : t_quad

  task automatic t_stepdir;
    logic [31:0] base;
    ahb_rd(`TIE_OFF_RAW, base);
    ahb_wr(`TIE_OFF_CTRL, 32'h203);
    enc_u.sd_pulse(1'b1);
    enc_u.sd_pulse(1'b1);
    rd_chk(`TIE_OFF_RAW, base + 32'd2);
    ahb_wr(`TIE_OFF_CTRL, 32'h303);
    repeat (3) enc_u.sd_pulse(1'b0);
    rd_chk(`TIE_OFF_RAW, base - 32'd1);
    $display("step direction done");
  endtask : t_stepdir

  task automatic t_gear;
    longint      r, sc, m;
    logic [31:0] nums [2];
    logic [31:0] dens [2];
    nums = '{32'hfffffffd, 32'h00000003};
    dens = '{32'h00000002, 32'h00000005};
    ahb_wr(`TIE_OFF_CTRL, 32'h3);
    repeat (9) enc_u.quad_step(1'b0);
    ahb_wr(`TIE_OFF_PPR, 32'h4);
    for (int i = 0; i < 2; i++) begin
      ahb_wr(`TIE_OFF_NUM, nums[i]);
      ahb_wr(`TIE_OFF_DEN, dens[i]);
      repeat (300) @(posedge hclk);
      ahb_rd(`TIE_OFF_RAW, rd);
      r = longint'($signed(rd));
      sc = (r * longint'($signed(nums[i]))) / longint'(dens[i]);
      m = sc / 4;
      if (sc < 0 && sc % 4 != 0) m = m - 1;
      rd_chk(`TIE_OFF_SINGLE, 32'(sc - m * 4));
      rd_chk(`TIE_OFF_MULTI, 32'(m));
    end
    $display("gearing done");
  endtask : t_gear

  task automatic t_index;
    logic [31:0] base;
    int          h;
    ahb_wr(`TIE_OFF_CTRL, 32'h3);
    ahb_rd(`TIE_OFF_IDXCNT, base);
    h = home_cnt;
    enc_u.index_pulse();
    check(32'(home_cnt - h), 32'h1);
    check({31'h0, probe}, 32'h0);
    ahb_wr(`TIE_OFF_CTRL, 32'h13);
    enc_u.index_pulse();
    check({31'h0, probe}, 32'h1);
    ahb_rd(`TIE_OFF_STATUS, rd);
    check({31'h0, rd[4]}, 32'h1);
    enc_u.index_pulse();
    check({31'h0, probe}, 32'h0);
    check(32'(home_cnt - h), 32'h1);
    rd_chk(`TIE_OFF_IDXCNT, base + 32'd3);
    ahb_wr(`TIE_OFF_CTRL, 32'h0);
    enc_u.index_pulse();
    check(32'(home_cnt - h), 32'h1);
    rd_chk(`TIE_OFF_IDXCNT, base + 32'd4);
    $display("index pulse done");
  endtask : t_index

  task automatic t_comm;
    logic [2:0] codes [6];
    codes = '{3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101};
    for (int i = 0; i < 6; i++) begin
      enc_u.comm(codes[i]);
      ahb_rd(`TIE_OFF_STATUS, rd);
      check({29'h0, rd[2:0]}, 32'(i + 1));
    end
    enc_u.comm(3'b111);
    ahb_rd(`TIE_OFF_STATUS, rd);
    check({26'h0, rd[5], 2'h0, rd[2:0]}, 32'h26);
    $display("commutation done");
  endtask : t_comm

  ////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    wr_sel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_limits();
    t_quad();
    t_stepdir();
    t_gear();
    t_index();
    t_comm();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
